// ==== hw/i2cscs_core.sv ====
// top of the two-wire sequence control and status block
//
// Contract
// - during acknowledge sequence drive the ack value bit: 1 is NACK, 0 ACK.
// - ack go starts acknowledge sequence; hardware clears it when sequence ends.
// - receive go clocks in one byte; cleared at end of eighth bit.
// - stop go generates Stop; hardware clears it when Stop ends.
// - restart go generates Repeated Start; hardware clears it when done.
// - start go generates Start; hardware clears it when Start ends.
// - stop-seen reads 1 when Stop was the last detected bus condition.
// - start-seen reads 1 when Start or Repeated Start was last detected.
// - slave direction updated after address byte: 1 read, 0 write.
// - receive full set when buffer written, cleared when software reads it.
// - transmit full set on buffer write, cleared when byte transmission completes.
`timescale 1ns/1ps
`default_nettype none
module i2cscs_core #(
  parameter int QTR_CYC = i2cscs_pkg::QTR_CYC
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst,
  // register port
  input  wire logic [i2cscs_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [i2cscs_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [i2cscs_pkg::DATA_W-1:0]    reg_rdata,
  // bus clock pin, open drain
  input  wire logic                             scl_in,
  output logic                                  scl_out,
  output logic                                  scl_oe,
  // bus data pin, open drain
  input  wire logic                             sda_in,
  output logic                                  sda_out,
  output logic                                  sda_oe
);
  if (QTR_CYC < 1 || QTR_CYC > 255) begin : g_chk
    $error("QTR_CYC must lie in 1..255");
  end

  i2cscs_mon_if mon_bus ();

  i2cscs_bus_mon u_mon (
    .clk     (clk),
    .rst     (rst),
    .scl_pin (scl_in),
    .sda_pin (sda_in),
    .bus     (mon_bus.mon)
  );

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [15:0]               ctrl_q, ctrl_d;
  logic [6:0]                own_q;
  logic [7:0]                tx_buf_q;
  logic [7:0]                rx_buf_q;
  logic                      tx_full_q, rx_full_q;
  logic                      dir_q, start_seen_q, stop_seen_q, ack_rx_q;
  logic                      hold_scl_q;
  i2cscs_pkg::i2cscs_state_t st_q, st_d;
  logic [1:0]                ph_q, ph_d;
  logic [7:0]                tick_q, tick_d;
  logic [3:0]                bit_q, bit_d;
  logic [7:0]                sh_q, sh_d;
  logic                      scl_low_q, sda_low_q;
  logic                      scl_low_d, sda_low_d;
  logic [15:0]               rdata_q;

  // ---------------------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------------------
  wire wr_ctrl = reg_wr & (reg_addr == i2cscs_pkg::REG_CTRL);
  wire wr_tx   = reg_wr & (reg_addr == i2cscs_pkg::REG_TX);
  wire wr_own  = reg_wr & (reg_addr == i2cscs_pkg::REG_OWN);
  wire rd_rx   = reg_rd & (reg_addr == i2cscs_pkg::REG_RX);
  wire busy    = st_q != i2cscs_pkg::ST_IDLE;
  wire enabled = ctrl_q[i2cscs_pkg::CTRL_ENABLE];

  wire [15:0] stat_word = {9'h000, busy, ack_rx_q, stop_seen_q, start_seen_q,
                           dir_q, rx_full_q, tx_full_q};
  wire [15:0] rd_mux =
    (reg_addr == i2cscs_pkg::REG_CTRL) ? ctrl_q :
    (reg_addr == i2cscs_pkg::REG_STAT) ? stat_word :
    (reg_addr == i2cscs_pkg::REG_TX)   ? {8'h00, tx_buf_q} :
    (reg_addr == i2cscs_pkg::REG_RX)   ? {8'h00, rx_buf_q} :
    (reg_addr == i2cscs_pkg::REG_OWN)  ? {9'h000, own_q} : 16'h0000;

  // ---------------------------------------------------------------------------
  // bit timing
  // ---------------------------------------------------------------------------
  // a slave holding the clock low stretches the high phases
  wire stall    = busy & ~scl_low_q & ~mon_bus.scl_s;
  wire tick_end = ~stall & (tick_q == 8'(QTR_CYC - 1));
  wire ph_last  = tick_end & (ph_q == 2'h3);
  wire sample   = tick_end & (ph_q == 2'h2);
  wire last_bit = (st_q == i2cscs_pkg::ST_TX) ? (bit_q == i2cscs_pkg::TX_LAST_BIT) :
                  (st_q == i2cscs_pkg::ST_RX) ? (bit_q == i2cscs_pkg::RX_LAST_BIT) : 1'b1;
  wire seq_done = busy & ph_last & last_bit;
  wire done_start   = seq_done & (st_q == i2cscs_pkg::ST_START);
  wire done_restart = seq_done & (st_q == i2cscs_pkg::ST_RESTART);
  wire done_stop    = seq_done & (st_q == i2cscs_pkg::ST_STOP);
  wire done_tx      = seq_done & (st_q == i2cscs_pkg::ST_TX);
  wire done_rx      = seq_done & (st_q == i2cscs_pkg::ST_RX);
  wire done_ack     = seq_done & (st_q == i2cscs_pkg::ST_ACK);
  wire [7:0] rx_byte = sh_q;

  // ---------------------------------------------------------------------------
  // control register: a software write in the clearing cycle wins
  // ---------------------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (done_start)
      ctrl_d[i2cscs_pkg::CTRL_START_GO] = 1'b0;
    if (done_restart)
      ctrl_d[i2cscs_pkg::CTRL_RESTART_GO] = 1'b0;
    if (done_stop)
      ctrl_d[i2cscs_pkg::CTRL_STOP_GO] = 1'b0;
    if (done_rx)
      ctrl_d[i2cscs_pkg::CTRL_RX_GO] = 1'b0;
    if (done_ack)
      ctrl_d[i2cscs_pkg::CTRL_ACK_GO] = 1'b0;
    if (wr_ctrl)
      ctrl_d = reg_wdata & 16'h803F;
  end

  // ---------------------------------------------------------------------------
  // sequencer; one request taken at a time, in fixed priority
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    ph_d   = ph_q;
    tick_d = tick_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    case (st_q)
      i2cscs_pkg::ST_IDLE: begin
        ph_d   = 2'h0;
        tick_d = 8'h00;
        bit_d  = 4'h0;
        if (enabled) begin
          if (ctrl_q[i2cscs_pkg::CTRL_START_GO])
            st_d = i2cscs_pkg::ST_START;
          else if (ctrl_q[i2cscs_pkg::CTRL_RESTART_GO])
            st_d = i2cscs_pkg::ST_RESTART;
          else if (ctrl_q[i2cscs_pkg::CTRL_STOP_GO])
            st_d = i2cscs_pkg::ST_STOP;
          else if (ctrl_q[i2cscs_pkg::CTRL_RX_GO]) begin
            st_d = i2cscs_pkg::ST_RX;
            sh_d = i2cscs_pkg::BYTE_RST;
          end else if (ctrl_q[i2cscs_pkg::CTRL_ACK_GO])
            st_d = i2cscs_pkg::ST_ACK;
          else if (tx_full_q) begin
            st_d = i2cscs_pkg::ST_TX;
            sh_d = tx_buf_q;
          end
        end
      end
      default: begin
        if (!stall) begin
          if (tick_end) begin
            tick_d = 8'h00;
            ph_d   = ph_q + 2'h1;
          end else begin
            tick_d = tick_q + 8'h01;
          end
        end
        if (sample && st_q == i2cscs_pkg::ST_RX)
          sh_d = {sh_q[6:0], mon_bus.sda_s};
        if (ph_last) begin
          if (last_bit) begin
            st_d = i2cscs_pkg::ST_IDLE;
          end else begin
            bit_d = bit_q + 4'h1;
            if (st_q == i2cscs_pkg::ST_TX)
              sh_d = {sh_q[6:0], 1'b0};
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // pin levels per quarter phase
  // ---------------------------------------------------------------------------
  always_comb begin
    scl_low_d = 1'b0;
    sda_low_d = 1'b0;
    case (st_q)
      i2cscs_pkg::ST_IDLE: begin
        scl_low_d = hold_scl_q & enabled;
      end
      i2cscs_pkg::ST_START: begin
        scl_low_d = ph_q == 2'h3;
        sda_low_d = ph_q != 2'h0;
      end
      i2cscs_pkg::ST_RESTART: begin
        scl_low_d = (ph_q == 2'h0) | (ph_q == 2'h3);
        sda_low_d = ph_q[1];
      end
      i2cscs_pkg::ST_STOP: begin
        scl_low_d = ph_q == 2'h0;
        sda_low_d = ~ph_q[1];
      end
      i2cscs_pkg::ST_TX: begin
        scl_low_d = (ph_q == 2'h0) | (ph_q == 2'h3);
        sda_low_d = (bit_q != i2cscs_pkg::TX_LAST_BIT) & ~sh_q[7];
      end
      i2cscs_pkg::ST_RX: begin
        scl_low_d = (ph_q == 2'h0) | (ph_q == 2'h3);
      end
      i2cscs_pkg::ST_ACK: begin
        scl_low_d = (ph_q == 2'h0) | (ph_q == 2'h3);
        sda_low_d = ~ctrl_q[i2cscs_pkg::CTRL_ACK_VALUE];
      end
      default: begin
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= i2cscs_pkg::CTRL_RST;
      own_q  <= i2cscs_pkg::OWN_RST;
      st_q   <= i2cscs_pkg::ST_IDLE;
      ph_q   <= 2'h0;
      tick_q <= 8'h00;
      bit_q  <= 4'h0;
      sh_q   <= i2cscs_pkg::BYTE_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_own)
        own_q <= reg_wdata[6:0];
      st_q   <= st_d;
      ph_q   <= ph_d;
      tick_q <= tick_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buf_q  <= i2cscs_pkg::BYTE_RST;
      tx_full_q <= 1'b0;
      rx_buf_q  <= i2cscs_pkg::BYTE_RST;
      rx_full_q <= 1'b0;
      ack_rx_q  <= 1'b0;
    end else begin
      if (wr_tx)
        tx_buf_q <= reg_wdata[7:0];
      // a new write in the completion cycle keeps the flag set
      tx_full_q <= wr_tx | (tx_full_q & ~done_tx);
      if (done_rx)
        rx_buf_q <= rx_byte;
      rx_full_q <= done_rx | (rx_full_q & ~rd_rx);
      if (sample && st_q == i2cscs_pkg::ST_TX && bit_q == i2cscs_pkg::TX_LAST_BIT)
        ack_rx_q <= mon_bus.sda_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
      dir_q        <= 1'b0;
    end else begin
      if (mon_bus.start_det | mon_bus.stop_det) begin
        start_seen_q <= mon_bus.start_det;
        stop_seen_q  <= mon_bus.stop_det;
      end
      if (mon_bus.dir_upd)
        dir_q <= mon_bus.dir_val;
    end
  end

  // clock is held low between sequences until a stop or disabling releases it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_scl_q <= 1'b0;
      scl_low_q  <= 1'b0;
      sda_low_q  <= 1'b0;
      rdata_q    <= 16'h0000;
    end else begin
      if (done_stop | ~enabled)
        hold_scl_q <= 1'b0;
      else if (seq_done)
        hold_scl_q <= 1'b1;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      rdata_q   <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign mon_bus.own_addr = own_q;
  assign reg_rdata        = rdata_q;
  assign scl_out          = 1'b0;
  assign sda_out          = 1'b0;
  assign scl_oe           = scl_low_q;
  assign sda_oe           = sda_low_q;
endmodule
`default_nettype wire

// ==== hw/i2cscs_pkg.sv ====
// package and internal carrier of the two-wire sequence control and status block
package i2cscs_pkg;
  // ---------------------------------------------------------------------------
  // register map, word index on the plain register port
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 16;
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STAT    = 4'h1;
  localparam logic [3:0]  REG_TX      = 4'h2;
  localparam logic [3:0]  REG_RX      = 4'h3;
  localparam logic [3:0]  REG_OWN     = 4'h4;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_START_GO   = 0;
  localparam int CTRL_RESTART_GO = 1;
  localparam int CTRL_STOP_GO    = 2;
  localparam int CTRL_RX_GO      = 3;
  localparam int CTRL_ACK_GO     = 4;
  localparam int CTRL_ACK_VALUE  = 5;
  localparam int CTRL_ENABLE     = 15;
  localparam int STAT_TX_FULL    = 0;
  localparam int STAT_RX_FULL    = 1;
  localparam int STAT_DIR        = 2;
  localparam int STAT_START_SEEN = 3;
  localparam int STAT_STOP_SEEN  = 4;
  localparam int STAT_ACK_RX     = 5;
  localparam int STAT_BUSY       = 6;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [6:0]  OWN_RST     = 7'h00;
  localparam logic [7:0]  BYTE_RST    = 8'h00;

  // ---------------------------------------------------------------------------
  // timing: one bit of the bus is four quarter phases
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 800;
  localparam int QTR_CYC       = (SCL_PERIOD_NS / 4) / CLK_PERIOD_NS;
  localparam logic [3:0] TX_LAST_BIT = 4'h8;
  localparam logic [3:0] RX_LAST_BIT = 4'h7;
  localparam logic [2:0] ADDR_LAST_BIT = 3'h7;

  // ---------------------------------------------------------------------------
  // master sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_START   = 7'h02,
    ST_RESTART = 7'h04,
    ST_STOP    = 7'h08,
    ST_TX      = 7'h10,
    ST_RX      = 7'h20,
    ST_ACK     = 7'h40
  } i2cscs_state_t;
endpackage

// ---------------------------------------------------------------------------
// carrier between bus monitor and core
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
interface i2cscs_mon_if;
  logic       start_det;
  logic       stop_det;
  logic       dir_upd;
  logic       dir_val;
  logic       scl_s;
  logic       sda_s;
  logic [6:0] own_addr;
  modport mon  (input own_addr, output start_det, stop_det, dir_upd, dir_val, scl_s, sda_s);
  modport core (output own_addr, input start_det, stop_det, dir_upd, dir_val, scl_s, sda_s);
endinterface
`default_nettype wire

// ==== hw/i2cscs_bus_mon.sv ====
// bus monitor: pin synchronisers, start/stop detection, slave address direction
`timescale 1ns/1ps
`default_nettype none
module i2cscs_bus_mon (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // raw bus pins
  input  wire logic   scl_pin,
  input  wire logic   sda_pin,
  // core side
  i2cscs_mon_if.mon   bus
);
  logic       scl_m_q, scl_s_q, scl_p_q;
  logic       sda_m_q, sda_s_q, sda_p_q;
  logic       addr_act_q;
  logic [2:0] addr_cnt_q;
  logic [7:0] addr_sh_q;
  logic       dir_upd_q;
  logic       dir_val_q;

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  wire scl_high   = scl_s_q & scl_p_q;
  wire start_seen = scl_high & sda_p_q & ~sda_s_q;
  wire stop_seen  = scl_high & ~sda_p_q & sda_s_q;
  wire scl_rise   = scl_s_q & ~scl_p_q;
  wire [7:0] addr_byte = {addr_sh_q[6:0], sda_s_q};
  wire addr_end   = addr_act_q & scl_rise & (addr_cnt_q == i2cscs_pkg::ADDR_LAST_BIT);
  wire addr_match = addr_byte[7:1] == bus.own_addr;

  // second and third stages feed logic; first stage is read by nothing else
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_pin, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_pin, sda_m_q, sda_s_q};
    end
  end

  // ---------------------------------------------------------------------------
  // first byte after a start is the address; only a match updates direction
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_act_q <= 1'b0;
      addr_cnt_q <= 3'h0;
      addr_sh_q  <= i2cscs_pkg::BYTE_RST;
      dir_upd_q  <= 1'b0;
      dir_val_q  <= 1'b0;
    end else begin
      dir_upd_q <= addr_end & addr_match;
      if (addr_end)
        dir_val_q <= addr_byte[0];
      if (start_seen) begin
        addr_act_q <= 1'b1;
        addr_cnt_q <= 3'h0;
      end else if (stop_seen | addr_end) begin
        addr_act_q <= 1'b0;
      end else if (addr_act_q & scl_rise) begin
        addr_cnt_q <= addr_cnt_q + 3'h1;
        addr_sh_q  <= addr_byte;
      end
    end
  end

  assign bus.start_det = start_seen;
  assign bus.stop_det  = stop_seen;
  assign bus.dir_upd   = dir_upd_q;
  assign bus.dir_val   = dir_val_q;
  assign bus.scl_s     = scl_s_q;
  assign bus.sda_s     = sda_s_q;
endmodule
`default_nettype wire

// ==== testbench/i2cscs_core_chk.sv ====
// assertion checker for the two-wire sequence block top
`timescale 1ns/1ps
`default_nettype none
module i2cscs_core_chk #(
  parameter int QTR_CYC = 2
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // bus pins
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  // one sequence plus slack for the pin register
  localparam int SEQ_W = 6 * QTR_CYC;
  wire logic ctl_wr = reg_wr && reg_addr == 4'h0 && reg_wdata[15];
  wire logic idle   = !scl_oe && !sda_oe && scl_in && sda_in;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  unmapped_rd_a: assert property ($past(reg_rd) && $past(reg_addr) > 4'h4 |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  pins_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("open drain pin drives high");
  start_seq_a: assert property (ctl_wr && reg_wdata[0] && idle |->
    ##[1:SEQ_W] (sda_oe && !scl_oe)[*3] ##[1:SEQ_W] (sda_oe && scl_oe))
    else $error("start condition not made");
  stop_seq_a: assert property (ctl_wr && reg_wdata[4:0] == 5'h04 && scl_oe |->
    ##[1:SEQ_W] (!scl_oe && sda_oe) ##[1:SEQ_W] (!scl_oe && !sda_oe))
    else $error("stop condition not made");
  nack_drive_a: assert property (ctl_wr && reg_wdata[5:0] == 6'h30 && scl_oe |->
    ##[1:SEQ_W] ($fell(scl_oe) && !sda_oe))
    else $error("nack bit not released");
  ack_drive_a: assert property (ctl_wr && reg_wdata[5:0] == 6'h10 && scl_oe |->
    ##[1:SEQ_W] ($fell(scl_oe) && sda_oe))
    else $error("ack bit not driven");
  tx_full_a: assert property (reg_wr && reg_addr == 4'h2 ##1 reg_rd && reg_addr == 4'h1 |->
    ##1 reg_rdata[0])
    else $error("transmit full not set");
  rx_clear_a: assert property (reg_rd && reg_addr == 4'h3 ##1 reg_rd && reg_addr == 4'h1 |->
    ##1 !reg_rdata[1])
    else $error("receive full not cleared");
  off_quiet_a: assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[15] && idle |->
    ##1 (!scl_oe && !sda_oe)[*8])
    else $error("disabled block drives bus");
endmodule
bind i2cscs_core i2cscs_core_chk #(.QTR_CYC(QTR_CYC)) u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ==== testbench/i2cscs_peer.sv ====
// far bus party: byte source for master receive and a second master
`timescale 1ns/1ps
`default_nettype none
module i2cscs_peer (
  // resolved wires
  input  wire logic scl,
  input  wire logic sda,
  // pull-downs onto the wires
  output logic      scl_pull,
  output logic      sda_pull
);
  logic [7:0] pat;
  logic [8:0] seen;
  logic       feed;
  logic       m_scl;
  logic       m_sda;
  int         n;
  initial begin
    feed = 1'b0;
    m_scl = 1'b0;
    m_sda = 1'b0;
    n = 0;
    pat = 8'h00;
    seen = 9'h000;
  end
  assign scl_pull = m_scl;
  assign sda_pull = m_sda || (feed && !pat[7 - n]);
  // last nine bits clocked on the wire
  always @(posedge scl) seen <= {seen[7:0], sda};
  // next data bit only while scl is low
  always @(negedge scl) begin
    if (feed && n == 7)
      feed <= 1'b0;
    else if (feed)
      n <= n + 1;
  end
  task automatic give(input logic [7:0] b);
    pat = b;
    n = 0;
    feed = 1'b1;
  endtask
  // scl stands still outside these frames
  task automatic m_start();
    m_sda = 1'b1;
    #400;
    m_scl = 1'b1;
    #400;
  endtask
  task automatic m_byte(input logic [7:0] b);
    for (int i = 0; i < 9; i++) begin
      m_sda = (i < 8) && !b[7 - i];
      #200;
      m_scl = 1'b0;
      #400;
      m_scl = 1'b1;
      #200;
    end
  endtask
  task automatic m_stop();
    m_sda = 1'b1;
    #200;
    m_scl = 1'b0;
    #400;
    m_sda = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench of the two-wire sequence block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [3:0] A_CTL = i2cscs_pkg::REG_CTRL;
  localparam logic [3:0] A_ST  = i2cscs_pkg::REG_STAT;
  localparam logic [3:0] A_TX  = i2cscs_pkg::REG_TX;
  localparam logic [3:0] A_RX  = i2cscs_pkg::REG_RX;
  logic        clk, rst, reg_wr, reg_rd, scl_oe, sda_oe, scl_out, sda_out, p_scl, p_sda;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, d2;
  int          err_total, n_compared, cyc;
  // pull-up wires: low if any party pulls
  wire logic   scl_w = !(scl_oe || p_scl);
  wire logic   sda_w = !(sda_oe || p_sda);
  i2cscs_core #(.QTR_CYC(2)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  i2cscs_peer i_peer (.scl(scl_w), .sda(sda_w), .scl_pull(p_scl), .sda_pull(p_sda));
  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // back to back: write or read, then a read; answers in d and d2
  task automatic pair(input logic w, input logic [3:0] a1, input logic [15:0] v, input logic [3:0] a2);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a1;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a2;
    #1 d = reg_rdata;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d2 = reg_rdata;
  endtask
  // request a sequence, see its go bit stand, then wait for the clear
  task automatic go(input logic [15:0] ctl, input logic [15:0] m);
    wr(A_CTL, ctl);
    rd(A_CTL);
    chk(d & m, m);
    for (int k = 0; k < 60 && (d & m) != 16'h0000; k++) rd(A_CTL);
    chk(d & m, 16'h0000);
  endtask
  task automatic t_regs();
    rd(A_CTL);
    chk(d, 16'h0000);
    rd(A_ST);
    chk(d, 16'h0000);
    wr(A_ST, 16'h00FF);
    rd(A_ST);
    chk(d, 16'h0000);
    rd(4'hF);
    chk(d, 16'h0000);
  endtask
  task automatic t_off();
    wr(A_CTL, 16'h0001);
    repeat (20) @(posedge clk);
    chk({14'h0000, scl_oe, sda_oe}, 16'h0000);
    wr(A_CTL, 16'h0000);
    // let the quiet window after disabling run out before the next request
    repeat (8) @(posedge clk);
  endtask
  task automatic t_start();
    go(16'h8001, 16'h0001);
    rd(A_ST);
    chk(d & 16'h0018, 16'h0008);
    // clock stays held low after the start, data is let go
    chk({14'h0000, scl_oe, sda_oe}, 16'h0002);
  endtask
  task automatic t_tx();
    pair(1'b1, A_TX, 16'h005A, A_ST);
    chk(d2 & 16'h0001, 16'h0001);
    d = d2;
    for (int k = 0; k < 60 && d[0] !== 1'b0; k++) rd(A_ST);
    // no one acknowledges: nack seen, sequencer back to idle
    chk(d & 16'h0061, 16'h0020);
    // msb first, then the released ack bit
    chk({7'h00, i_peer.seen}, 16'h00B5);
  endtask
  task automatic t_restart();
    go(16'h8002, 16'h0002);
    rd(A_ST);
    chk(d & 16'h0018, 16'h0008);
  endtask
  task automatic t_rx(input logic [7:0] b, input logic nack);
    i_peer.give(b);
    go(16'h8008, 16'h0008);
    rd(A_ST);
    chk(d & 16'h0002, 16'h0002);
    pair(1'b0, A_RX, 16'h0000, A_ST);
    chk(d, {8'h00, b});
    chk(d2 & 16'h0002, 16'h0000);
    go(16'h8010 | {10'h000, nack, 5'h00}, 16'h0010);
  endtask
  task automatic t_stop();
    go(16'h8004, 16'h0004);
    rd(A_ST);
    chk(d & 16'h0018, 16'h0010);
    chk({14'h0000, scl_oe, sda_oe}, 16'h0000);
  endtask
  // another master addresses this device, read then write
  task automatic t_dir();
    wr(i2cscs_pkg::REG_OWN, 16'h002A);
    for (int b = 1; b >= 0; b--) begin
      i_peer.m_start();
      rd(A_ST);
      chk(d & 16'h0018, 16'h0008);
      i_peer.m_byte({7'h2A, b[0]});
      rd(A_ST);
      chk(d & 16'h0004, {13'h0000, b[0], 2'h0});
      i_peer.m_stop();
      rd(A_ST);
      chk(d & 16'h0018, 16'h0010);
    end
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_off();
    t_start();
    t_tx();
    // stop first so that the restart has to turn start-seen back on
    t_stop();
    t_restart();
    t_rx(8'hA5, 1'b1);
    t_rx(8'h3C, 1'b0);
    t_stop();
    t_dir();
    tally_and_finish();
  end
endmodule
`default_nettype wire
